// *** dv/spi_far_end.sv ***
/*
  Behavioural far end of the link: an SPI master or slave in clock mode 0,
  MSB first, with a 200 ns link clock.
  Assumes the bench resolves every line from the unit's output enables.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_far_end (
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic mosi_out,
  output logic miso_out,
  output logic sel_b_out
);
  logic [7:0] reply = 8'h00;
  logic [7:0] got = 8'h00;
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    sel_b_out = 1'b1;
  end
  // The link clock stands low between frames
  assign miso_out = reply[7];
  always @(negedge sck_in) reply <= {reply[6:0], ~reply[0]};
  always @(posedge sck_in) got <= {got[6:0], mosi_in};
  task automatic load(input logic [7:0] b);
    reply = b;
  endtask : load
  task automatic set_sel(input logic v);
    sel_b_out = v;
  endtask : set_sel
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      mosi_out = ~mosi_out;
      #100 sck_out = 1'b1;
      #100 sck_out = 1'b0;
    end
  endtask : pulses
  // The sole slave on the bus, so select may lead by a wide margin
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    sel_b_out = 1'b0;
    #400;
    for (int i = 7; i >= 0; i--) begin
      mosi_out = tx[i];
      #100 sck_out = 1'b1;
      rx[i] = miso_in;
      #100 sck_out = 1'b0;
    end
    #400 sel_b_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask : xfer
endmodule : spi_far_end
`default_nettype wire

// *** dv/test_spi_pin_and_select_modes.sv ***
/*
  Self-checking bench for the serial port unit: pin directions, select
  modes, master and slave bytes, mode fault and the transmit FIFO.
  Assumes the far end model and a 40 MHz system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_spi_pin_and_select_modes import spi_port_pkg::*;;
  localparam logic [4:0] K_MST = 5'h10;
  localparam logic [4:0] K_PRT = 5'h08;
  localparam logic [4:0] K_CLR = 5'h04;
  localparam logic [4:0] K_MF = 5'h02;
  localparam logic [4:0] K_TD = 5'h01;
  logic clk_in;
  logic rst_b = 1'b0;
  logic m_set = 1'b0, p_set = 1'b0, en_clr = 1'b0, mf_clr = 1'b0;
  logic td_clr = 1'b0, tx_valid = 1'b0;
  logic [1:0] mode = SEL_MODE_RST;
  logic [7:0] tx_data = 8'h00, tx, rep, rx, rx_data;
  logic tx_ready, me, pe, mf, td, pinned;
  logic far_sck, far_mosi, far_miso, far_sel_b;
  pin_drive_t pins;
  int failures = 0, comparisons = 0, seed = 69, n, cycles = 0;
  wire logic mosi_w = pins.mosi_oe ? pins.mosi_o : far_mosi;
  wire logic miso_w = pins.miso_oe ? pins.miso_o : far_miso;
  wire logic sck_w = pins.sck_oe ? pins.sck_o : far_sck;
  wire logic sel_w = pins.sel_oe ? pins.sel_o : far_sel_b;

  serial_port_unit dut_u (.clk_in(clk_in), .rst_b_in(rst_b),
    .select_mode_field_in(mode), .master_enable_set_in(m_set),
    .port_enable_set_in(p_set), .enable_clear_in(en_clr),
    .master_enable_bit_out(me), .port_enable_bit_out(pe),
    .mode_fault_flag_out(mf), .mode_fault_clr_in(mf_clr),
    .transfer_done_flag_out(td), .transfer_done_clr_in(td_clr),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .tx_data_in(tx_data), .rx_data_out(rx_data),
    .select_pinned_out(pinned), .mosi_in(mosi_w), .miso_in(miso_w),
    .sck_in(sck_w), .slave_select_line_in(sel_w), .pins_out(pins));
  spi_far_end far_u (.sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w),
    .sck_out(far_sck), .mosi_out(far_mosi), .miso_out(far_miso),
    .sel_b_out(far_sel_b));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  function automatic logic [7:0] exp_pinned(input int m);
    return (m != 0) ? 8'h01 : 8'h00;
  endfunction : exp_pinned
  function automatic logic [7:0] exp_sel(input int m);
    return (m >= 2) ? 8'(m) : 8'h00;
  endfunction : exp_sel
  task automatic report_and_stop;
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask : tick
  task automatic strobe(input logic [4:0] m);
    @(posedge clk_in);
    m_set <= m[4];
    p_set <= m[3];
    en_clr <= m[2];
    mf_clr <= m[1];
    td_clr <= m[0];
    @(posedge clk_in);
    m_set <= 1'b0;
    p_set <= 1'b0;
    en_clr <= 1'b0;
    mf_clr <= 1'b0;
    td_clr <= 1'b0;
  endtask : strobe
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_in) mode <= m;
    tick(3);
  endtask : set_mode
  task automatic push(input logic [7:0] b);
    @(posedge clk_in) tx_valid <= 1'b1;
    tx_data <= b;
    do @(posedge clk_in); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask : push
  task automatic wait_done;
    for (int i = 0; i < 400 && td !== 1'b1; i++) @(posedge clk_in);
    check({7'h00, td}, 8'h01);
    strobe(K_TD);
  endtask : wait_done

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(8);
    rst_b <= 1'b1;
    tick(2);
    check({5'h00, pins.miso_oe, pins.mosi_oe, pins.sck_oe}, 8'h00);
    // Select-output modes only visited with the port disabled
    for (int m = 0; m < 4; m++) begin
      set_mode(2'(m));
      check({7'h00, pinned}, exp_pinned(m));
      check({6'h00, pins.sel_oe, pins.sel_o & pins.sel_oe}, exp_sel(m));
    end
    set_mode(SEL_THREE_LINE);
    strobe(K_MST | K_PRT);
    for (int k = 0; k < 3; k++) begin
      tx = (k == 0) ? 8'h80 : 8'($random(seed));
      rep = (k == 0) ? 8'h01 : 8'($random(seed));
      far_u.load(rep);
      push(tx);
      tick(12);
      check({5'h00, pins.mosi_oe, pins.sck_oe, pins.miso_oe}, 8'h06);
      wait_done();
      check(far_u.got, tx);
      check(rx_data, rep);
    end
    strobe(K_CLR);
    set_mode(SEL_FOUR_LINE_IN);
    strobe(K_PRT);
    tx = 8'($random(seed));
    push(tx);
    tick(4);
    check({5'h00, pins.miso_oe, pins.mosi_oe, pins.sck_oe}, 8'h00);
    far_u.pulses(8);
    tick(8);
    check({7'h00, td}, 8'h00);
    rep = 8'($random(seed));
    fork
      far_u.xfer(rep, rx);
      begin
        tick(32);
        check({7'h00, pins.miso_oe}, 8'h01);
      end
    join
    wait_done();
    check(rx_data, rep);
    check(rx, tx);
    far_u.set_sel(1'b0);
    far_u.pulses(3);
    far_u.set_sel(1'b1);
    tick(4);
    rep = 8'($random(seed));
    far_u.xfer(rep, rx);
    wait_done();
    check(rx_data, rep);
    set_mode(SEL_THREE_LINE);
    tick(4);
    check({7'h00, pins.miso_oe}, 8'h01);
    far_u.pulses(8);
    wait_done();
    strobe(K_CLR);
    set_mode(SEL_FOUR_LINE_IN);
    strobe(K_MST | K_PRT);
    far_u.set_sel(1'b0);
    tick(6);
    check({5'h00, mf, me, pe}, 8'h04);
    far_u.set_sel(1'b1);
    strobe(K_MF);
    tick(1);
    check({7'h00, mf}, 8'h00);
    @(posedge clk_in) tx_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      if (tx_ready === 1'b1) n++;
      tx_data <= 8'($random(seed));
    end while (tx_ready === 1'b1 && n < 40);
    tx_valid <= 1'b0;
    check(8'(n), 8'(FIFO_DEPTH));
    set_mode(SEL_THREE_LINE);
    strobe(K_MST | K_PRT);
    tick(200);
    check({7'h00, tx_ready}, 8'h01);
    report_and_stop();
  end
endmodule : test_spi_pin_and_select_modes
`default_nettype wire

// *** rtl/byte_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes write and read on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff;
  logic [AW:0] cnt_ff;
  wire do_wr = in_valid_in && in_ready_out;
  wire do_rd = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out = mem[rd_ff];

  always_ff @(posedge clk_in) begin
    if (do_wr) mem[wr_ff] <= in_data_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_wr) wr_ff <= wr_ff + 1'b1;
      if (do_rd) rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : byte_fifo
`default_nettype wire

// *** rtl/serial_port_unit.sv ***
/*
  Serial port unit: SPI master or slave, three or four line, MSB first,
  with select-line modes, mode fault and a transmit FIFO.
  Assumes link pins are asynchronous and are resolved by the bench.
*/
// Overview of operation
// - Master or slave, three or four line
// - Data-out line driven as master, sampled slave
// - All bytes shifted most significant bit first
// - Master drives data-out from shift MSB
// - Data-in line input master, output slave
// - Slave output tristated when disabled or unselected
// - Three-line slave always drives shift MSB
// - Clock generated as master, accepted as slave
// - Unselected four-line slave ignores clock
// - Mode 00: three line, slave always selected
// - Mode 01: select line is input
// - Mode 01 master: select fall disables master
// - Mode 1x: select output equals low bit
// - Select line pinned except in three-line mode
// - Mode fault clears enables, sets fault flag
// - Select falling edge resets slave bit counter
// - Slave byte done sets flag, stores byte
`timescale 1ns/10ps
`default_nettype none
module serial_port_unit
  import spi_port_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [1:0] select_mode_field_in,
  input wire logic master_enable_set_in,
  input wire logic port_enable_set_in,
  input wire logic enable_clear_in,
  output logic master_enable_bit_out,
  output logic port_enable_bit_out,
  output logic mode_fault_flag_out,
  input wire logic mode_fault_clr_in,
  output logic transfer_done_flag_out,
  input wire logic transfer_done_clr_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic [7:0] tx_data_in,
  output logic [7:0] rx_data_out,
  output logic select_pinned_out,
  input wire logic mosi_in,
  input wire logic miso_in,
  input wire logic sck_in,
  input wire logic slave_select_line_in,
  output pin_drive_t pins_out
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [3:0] s1_ff, s2_ff;
  logic sck_prev_ff, sel_prev_ff;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // Link clock resets to its idle low level to avoid a false edge
      s1_ff <= 4'hD;
      s2_ff <= 4'hD;
    end else begin
      s1_ff <= {mosi_in, miso_in, sck_in, slave_select_line_in};
      s2_ff <= s1_ff;
    end
  end
  wire mosi_s = s2_ff[3];
  wire miso_s = s2_ff[2];
  wire sck_s = s2_ff[1];
  wire sel_s = s2_ff[0];
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_prev_ff <= 1'b0;
      sel_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= sck_s;
      sel_prev_ff <= sel_s;
    end
  end
  wire sel_fall = sel_prev_ff && !sel_s;

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  logic [1:0] mode_ff;
  logic master_enable_bit_ff, port_enable_bit_ff, mode_fault_flag_ff, done_ff;
  wire three_line = (mode_ff == SEL_THREE_LINE);
  wire four_in = (mode_ff == SEL_FOUR_LINE_IN);
  wire sel_out_mode = mode_ff[1];
  wire is_master = port_enable_bit_ff && master_enable_bit_ff;
  wire is_slave = port_enable_bit_ff && !master_enable_bit_ff;
  // Three-line slave counts as permanently selected
  wire slave_sel = is_slave && (three_line || (four_in && !sel_s));
  wire fault = is_master && four_in && sel_fall;

  // Registered copy keeps the select output glitch free
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) mode_ff <= SEL_MODE_RST;
    else mode_ff <= select_mode_field_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      master_enable_bit_ff <= 1'b0;
      port_enable_bit_ff <= 1'b0;
    end else if (fault || enable_clear_in) begin
      master_enable_bit_ff <= 1'b0;
      port_enable_bit_ff <= 1'b0;
    end else begin
      if (master_enable_set_in) master_enable_bit_ff <= 1'b1;
      if (port_enable_set_in) port_enable_bit_ff <= 1'b1;
    end
  end

  // Set wins over a simultaneous software clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) mode_fault_flag_ff <= 1'b0;
    else if (fault) mode_fault_flag_ff <= 1'b1;
    else if (mode_fault_clr_in) mode_fault_flag_ff <= 1'b0;
  end

  // ------------------------------------------------------------
  // Transmit buffer
  // ------------------------------------------------------------
  logic fifo_valid, fifo_take;
  logic [7:0] fifo_data;
  byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .in_data_in(tx_data_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_take),
    .out_data_out(fifo_data)
  );

  // ------------------------------------------------------------
  // Shift engine (mode 0 timing: sample on rise, shift on fall)
  // ------------------------------------------------------------
  mst_state_t st_ff, nxt_st;
  logic [7:0] shift_ff, rx_ff;
  logic [2:0] bit_ff;
  logic [7:0] div_ff;
  logic sample_ff, loaded_ff, sck_drv_ff;
  wire div_tick = (div_ff == 8'(HALF_CYC - 1));
  wire s_rise = slave_sel && !sck_prev_ff && sck_s;
  wire s_fall = slave_sel && sck_prev_ff && !sck_s;
  wire m_rise = (st_ff == ST_LOW) && div_tick;
  wire m_fall = (st_ff == ST_HIGH) && div_tick;
  wire m_start = (st_ff == ST_IDLE) && is_master && fifo_valid;
  wire in_bit = is_master ? miso_s : mosi_s;
  wire do_rise = m_rise || s_rise;
  wire do_fall = m_fall || s_fall;
  wire byte_end = do_fall && (bit_ff == BIT_CNT_LAST);
  wire s_load = is_slave && !loaded_ff && fifo_valid;
  assign fifo_take = m_start || s_load;

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: if (m_start) nxt_st = ST_LOW;
      ST_LOW: if (div_tick) nxt_st = ST_HIGH;
      ST_HIGH: if (div_tick) nxt_st = byte_end ? ST_IDLE : ST_LOW;
      default: nxt_st = ST_IDLE;
    endcase
    if (!is_master) nxt_st = ST_IDLE;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= ST_IDLE;
      div_ff <= 8'h00;
      sck_drv_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      div_ff <= (st_ff == ST_IDLE || div_tick) ? 8'h00 : div_ff + 8'h01;
      sck_drv_ff <= (nxt_st == ST_HIGH);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shift_ff <= BYTE_RST;
      bit_ff <= BIT_CNT_RST;
      sample_ff <= 1'b0;
      loaded_ff <= 1'b0;
    end else if (!port_enable_bit_ff) begin
      bit_ff <= BIT_CNT_RST;
      loaded_ff <= 1'b0;
    end else begin
      if (is_slave && four_in && sel_fall) bit_ff <= BIT_CNT_RST;
      else if (do_fall) bit_ff <= bit_ff + 3'h1;
      if (do_rise) sample_ff <= in_bit;
      if (fifo_take) begin
        shift_ff <= fifo_data;
        loaded_ff <= 1'b1;
      end else if (do_fall) begin
        shift_ff <= {shift_ff[6:0], sample_ff};
        if (byte_end) loaded_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_ff <= BYTE_RST;
      done_ff <= 1'b0;
    end else if (byte_end) begin
      rx_ff <= {shift_ff[6:0], sample_ff};
      done_ff <= 1'b1;
    end else if (transfer_done_clr_in) begin
      done_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  wire miso_en = is_slave && (three_line || (four_in && !sel_s));
  assign pins_out.mosi_o = shift_ff[7];
  assign pins_out.mosi_oe = is_master;
  assign pins_out.miso_o = shift_ff[7];
  assign pins_out.miso_oe = miso_en;
  assign pins_out.sck_o = sck_drv_ff;
  assign pins_out.sck_oe = is_master;
  assign pins_out.sel_o = mode_ff[0];
  assign pins_out.sel_oe = sel_out_mode;
  assign select_pinned_out = !three_line;
  assign master_enable_bit_out = master_enable_bit_ff;
  assign port_enable_bit_out = port_enable_bit_ff;
  assign mode_fault_flag_out = mode_fault_flag_ff;
  assign transfer_done_flag_out = done_ff;
  assign rx_data_out = rx_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_miso_tristate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!port_enable_bit_ff || (four_in && sel_s)) |-> !pins_out.miso_oe)
    else $error("slave output driven while not selected");
  chk_fault_clears: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    fault |=> (mode_fault_flag_ff && !master_enable_bit_ff && !port_enable_bit_ff))
    else $error("mode fault did not disable port");
  chk_sel_follows: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    select_mode_field_in[1] |=> (pins_out.sel_oe &&
      pins_out.sel_o == $past(select_mode_field_in[0])))
    else $error("select output not following low bit");
  chk_mosi_dir: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pins_out.mosi_oe == is_master)
    else $error("data-out direction wrong");
  chk_done_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    byte_end |=> (done_ff && rx_ff == $past({shift_ff[6:0], sample_ff})))
    else $error("byte end did not store byte");
  chk_cnt_reset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (port_enable_bit_ff && is_slave && four_in && sel_fall) |=> bit_ff == BIT_CNT_RST)
    else $error("bit counter not reset on select fall");
  chk_ignore_clk: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (is_slave && four_in && sel_s) |-> !(s_rise || s_fall))
    else $error("unselected slave saw clock");
  chk_pin_map: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    three_line |-> (!select_pinned_out && !pins_out.sel_oe))
    else $error("select pinned in three-line mode");
  chk_master_clk: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    m_start |=> (!pins_out.sck_o ##[1:16] pins_out.sck_o))
    else $error("master clock did not toggle");
endmodule : serial_port_unit
`default_nettype wire

// *** rtl/spi_port_pkg.sv ***
/*
  Shared constants and types for the serial port unit: select modes,
  reset values, bit counts and the grouped pin signals.
  Assumes a single 40 MHz system clock domain.
*/
package spi_port_pkg;
  localparam int BYTE_W = 8;
  localparam logic [1:0] SEL_THREE_LINE = 2'h0;
  localparam logic [1:0] SEL_FOUR_LINE_IN = 2'h1;
  localparam logic [1:0] SEL_MODE_RST = 2'h1;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int CLK_HZ = 40000000;
  localparam int SCK_HALF_CYC = 4;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic sck_o;
    logic sck_oe;
    logic sel_o;
    logic sel_oe;
  } pin_drive_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b100
  } mst_state_t;
endpackage : spi_port_pkg
